/* File: port_select_defines.svh */
`ifndef PORT_SELECT_DEFINES_SVH
`define PORT_SELECT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define LAS_OFFSET 8'h1e
`define PCE_OFFSET 8'h1f
`define BC_ERR_OFFSET 8'h1b

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define LAS_RESET 8'h01
`define LAS_A_BIT 0
`define LAS_B_BIT 1
`define LAS_EN_BIT 2
`define LAS_FIELD_MSB 2
`define LAS_RSVD_ZERO 5'h00
`define PCE_RESET 8'h00
`define PCE_MAX 8'hff
`define PCE_ONE 8'h01
`define ADDR_STEP 7'h01

`endif

/* File: port_select_pkg.sv */
package port_select_pkg;

  typedef enum logic [0:0] {
    CNT_IDLE = 1'b0,
    CNT_RUN  = 1'b1
  } cnt_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage

/* File: edge_counter.sv */
`timescale 1ns/1ns
`include "port_select_defines.svh"

module edge_counter import port_select_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic pix_clk_i,
  input wire logic start_i,
  input wire reg_byte_t interval_i,
  output reg_byte_t count_o,
  output logic busy_o
);

  // --------------------------------------------------------------------
  // Pixel clock synchroniser and edge detect
  // --------------------------------------------------------------------
  logic pix_meta_q;
  logic pix_sync_q;
  logic pix_prev_q;
  wire pix_rise = pix_sync_q & ~pix_prev_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pix_meta_q <= 1'b0;
      pix_sync_q <= 1'b0;
      pix_prev_q <= 1'b0;
    end else begin
      pix_meta_q <= pix_clk_i;
      pix_sync_q <= pix_meta_q;
      pix_prev_q <= pix_sync_q;
    end
  end

  // --------------------------------------------------------------------
  // Interval timer and saturating edge count
  // --------------------------------------------------------------------
  function automatic reg_byte_t sat_inc(input reg_byte_t v);
    sat_inc = (v == `PCE_MAX) ? v : v + `PCE_ONE;
  endfunction

  cnt_state_t state_q;
  cnt_state_t state_d;
  reg_byte_t remain_q;
  reg_byte_t remain_d;
  reg_byte_t count_q;
  reg_byte_t count_d;

  // A zero interval clears the count and never opens the window
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    count_d = count_q;
    unique case (state_q)
      CNT_IDLE: begin
      end
      CNT_RUN: begin
        remain_d = remain_q - `PCE_ONE;
        if (pix_rise) begin
          count_d = sat_inc(count_q);
        end
        if (remain_q == `PCE_ONE) begin
          state_d = CNT_IDLE;
        end
      end
    endcase
    if (start_i) begin
      count_d = `PCE_RESET;
      remain_d = interval_i;
      state_d = (interval_i == `PCE_RESET) ? CNT_IDLE : CNT_RUN;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= CNT_IDLE;
      remain_q <= `PCE_RESET;
      count_q <= `PCE_RESET;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      count_q <= count_d;
    end
  end

  assign count_o = count_q;
  assign busy_o = (state_q == CNT_RUN);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_start_window: assert property (
    start_i && interval_i != `PCE_RESET |=> busy_o && count_q == `PCE_RESET
      && remain_q == $past(interval_i))
    else $error("Counter window did not open on start");

  a_window_end: assert property (
    busy_o && remain_q == `PCE_ONE && !start_i |=> !busy_o)
    else $error("Counter window did not close on time");

  a_count_sat: assert property (
    count_q == `PCE_MAX && !start_i |=> count_q == `PCE_MAX)
    else $error("Edge count wrapped past maximum");

  a_count_idle: assert property (
    !busy_o && !start_i |=> $stable(count_q))
    else $error("Edge count moved outside the window");

  c_saturate: cover property (busy_o && count_q == `PCE_MAX);

endmodule // edge_counter

/* File: port_select_freq_counter.sv */
//
// Behaviour
// - With second address enabled, also answer at configured address plus one.
// - Second address reaches link B registers and shared registers.
// - Replicate mode forwards remote accesses on link B only if enabled.
// - Link B select: primary writes update link B and shared registers.
// - Link B select: primary reads return link B and shared registers.
// - Link A select: primary writes update link A and shared registers.
// - Both selects set: primary reads return link B contents.
// - Select bits ignored for primary steering while second address enabled.
// - Writing the counter register starts a pixel edge measurement.
// - Interval lasts written value times the oscillator clock period.
// - Reading the counter register returns edges seen during the interval.
// - Edge count saturates at its maximum instead of wrapping.
// - Per-link status registers report link B while link B select set.
//
`timescale 1ns/1ns
`include "port_select_defines.svh"

module port_select_freq_counter import port_select_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic pix_clk_i,
  input wire logic [6:0] configured_device_address_i,
  input wire logic replicate_mode_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [6:0] acc_dev_addr_i,
  input wire reg_byte_t acc_reg_addr_i,
  input wire reg_byte_t acc_wdata_i,
  input wire reg_byte_t link_a_rdata_i,
  input wire reg_byte_t link_b_rdata_i,
  output logic acc_ack_o,
  output reg_byte_t acc_rdata_o,
  output reg_byte_t reg_addr_o,
  output reg_byte_t reg_wdata_o,
  output logic wr_link_a_o,
  output logic wr_link_b_o,
  output logic wr_shared_o,
  output logic remote_fwd_link_b_o
);

  // --------------------------------------------------------------------
  // Address match and steering
  // --------------------------------------------------------------------
  reg_byte_t las_q;
  reg_byte_t pce_count;
  logic pce_busy;

  wire sec_en = las_q[`LAS_EN_BIT];
  wire sel_a = las_q[`LAS_A_BIT];
  wire sel_b = las_q[`LAS_B_BIT];
  wire [6:0] sec_addr = configured_device_address_i + `ADDR_STEP;
  wire prim_hit = acc_valid_i && acc_dev_addr_i == configured_device_address_i;
  wire sec_hit = acc_valid_i && sec_en && acc_dev_addr_i == sec_addr;
  wire any_hit = prim_hit | sec_hit;
  wire is_las = acc_reg_addr_i == `LAS_OFFSET;
  wire is_pce = acc_reg_addr_i == `PCE_OFFSET;
  wire is_local = is_las | is_pce;
  wire do_write = any_hit & acc_write_i;

  // Once the second address is on, primary always means link A
  wire to_b = sec_hit | (prim_hit & ~sec_en & sel_b);
  wire to_a = prim_hit & (sec_en | sel_a);
  // Link B wins a read when both selects are set
  wire read_b = to_b;
  wire reg_byte_t link_rdata = read_b ? link_b_rdata_i : link_a_rdata_i;
  wire reg_byte_t local_rdata = is_las ? las_q : pce_count;
  wire reg_byte_t rdata_d = is_local ? local_rdata : link_rdata;
  wire pce_start = do_write & is_pce;

  // --------------------------------------------------------------------
  // Registers and registered outputs
  // --------------------------------------------------------------------
  // Link read data is taken in the request cycle, so the link register
  // files must decode reg address combinationally on the same clock.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      las_q <= `LAS_RESET;
      acc_ack_o <= 1'b0;
      acc_rdata_o <= `PCE_RESET;
      reg_addr_o <= `PCE_RESET;
      reg_wdata_o <= `PCE_RESET;
      wr_link_a_o <= 1'b0;
      wr_link_b_o <= 1'b0;
      wr_shared_o <= 1'b0;
      remote_fwd_link_b_o <= 1'b0;
    end else begin
      if (do_write && is_las) begin
        las_q <= {`LAS_RSVD_ZERO, acc_wdata_i[`LAS_FIELD_MSB:0]};
      end
      acc_ack_o <= any_hit;
      if (any_hit) begin
        acc_rdata_o <= rdata_d;
        reg_addr_o <= acc_reg_addr_i;
        reg_wdata_o <= acc_wdata_i;
      end
      wr_link_a_o <= do_write & ~is_local & to_a;
      wr_link_b_o <= do_write & ~is_local & to_b;
      // Shared registers follow any link write, whichever link is picked
      wr_shared_o <= do_write & ~is_local & (to_a | to_b);
      remote_fwd_link_b_o <= replicate_mode_i & sec_en;
    end
  end

  // --------------------------------------------------------------------
  // Pixel clock frequency counter
  // --------------------------------------------------------------------
  edge_counter u_edge_counter (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .pix_clk_i(pix_clk_i),
    .start_i(pce_start),
    .interval_i(acc_wdata_i),
    .count_o(pce_count),
    .busy_o(pce_busy)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_second_addr_ack: assert property (
    acc_valid_i && sec_en && acc_dev_addr_i == sec_addr |=> acc_ack_o)
    else $error("Second address not answered");

  a_second_addr_off: assert property (
    acc_valid_i && !sec_en && acc_dev_addr_i == sec_addr
      && acc_dev_addr_i != configured_device_address_i |=> !acc_ack_o)
    else $error("Second address answered while disabled");

  a_second_link_b: assert property (
    sec_hit && acc_write_i && !is_local
      |=> wr_link_b_o && wr_shared_o && !wr_link_a_o)
    else $error("Second address write not steered to link B");

  a_fwd_gate: assert property (
    remote_fwd_link_b_o |-> $past(replicate_mode_i) && $past(sec_en))
    else $error("Forwarding on link B without enable");

  a_b_write: assert property (
    prim_hit && acc_write_i && !is_local && !sec_en && sel_b
      |=> wr_link_b_o && wr_shared_o)
    else $error("Link B select write not steered");

  a_b_read: assert property (
    prim_hit && !acc_write_i && !is_local && !sec_en && sel_b
      |=> acc_rdata_o == $past(link_b_rdata_i))
    else $error("Link B select read returned wrong data");

  a_a_write: assert property (
    prim_hit && acc_write_i && !is_local && !sec_en && sel_a && !sel_b
      |=> wr_link_a_o && wr_shared_o && !wr_link_b_o)
    else $error("Link A select write not steered");

  a_both_read: assert property (
    prim_hit && !is_local && !sec_en && sel_a && sel_b
      |=> acc_rdata_o == $past(link_b_rdata_i))
    else $error("Both selects did not read link B");

  a_sel_ignored: assert property (
    prim_hit && acc_write_i && !is_local && sec_en |=> !wr_link_b_o)
    else $error("Select bits steered while second address on");

  a_count_read: assert property (
    any_hit && is_pce && !acc_write_i |=> acc_rdata_o == $past(pce_count))
    else $error("Counter read returned wrong value");

  a_ack_only_hit: assert property (
    !any_hit |=> !acc_ack_o)
    else $error("Acknowledge without address match");

  a_second_read: assert property (
    sec_hit && !acc_write_i && !is_local
      |=> acc_rdata_o == $past(link_b_rdata_i))
    else $error("Second address read not from link B");

  a_fwd_set: assert property (
    replicate_mode_i && sec_en |=> remote_fwd_link_b_o)
    else $error("Forwarding on link B not raised");

  a_addr_capture: assert property (
    any_hit |=> reg_addr_o == $past(acc_reg_addr_i)
      && reg_wdata_o == $past(acc_wdata_i))
    else $error("Register address or data not captured");

  a_local_quiet: assert property (
    any_hit && is_local |=> !wr_link_a_o && !wr_link_b_o && !wr_shared_o)
    else $error("Local register access strobed a link file");

  a_read_quiet: assert property (
    any_hit && !acc_write_i
      |=> !wr_link_a_o && !wr_link_b_o && !wr_shared_o)
    else $error("Read access raised a write strobe");

  a_a_read: assert property (
    prim_hit && !acc_write_i && !is_local && !sec_en && !sel_b
      |=> acc_rdata_o == $past(link_a_rdata_i))
    else $error("Link A read returned wrong data");

  a_enabled_prim: assert property (
    prim_hit && acc_write_i && !is_local && sec_en
      |=> wr_link_a_o && wr_shared_o)
    else $error("Primary write not steered to link A");

  a_select_write: assert property (
    any_hit && acc_write_i && is_las
      |=> las_q == {`LAS_RSVD_ZERO, $past(acc_wdata_i[`LAS_FIELD_MSB:0])})
    else $error("Link select register not written");

  a_count_start: assert property (
    pce_start |=> pce_busy || $past(acc_wdata_i) == `PCE_RESET)
    else $error("Counter write did not open a window");

  a_b_status: assert property (
    prim_hit && !acc_write_i && !sec_en && sel_b
      && acc_reg_addr_i == `BC_ERR_OFFSET
      |=> acc_rdata_o == $past(link_b_rdata_i))
    else $error("Status register not read from link B");

  c_second_write: cover property (sec_hit && acc_write_i && !is_local);
  c_both_sel_read: cover property (prim_hit && !acc_write_i && sel_a && sel_b);
  c_measure: cover property (pce_start ##1 pce_busy [*8]);
  c_bc_err_b: cover property (prim_hit && sel_b
    && acc_reg_addr_i == `BC_ERR_OFFSET);

endmodule // port_select_freq_counter

/* File: link_regs_model.sv */
`timescale 1ns/1ns
// ----
// Link A and link B register files behind the steering block
// ----
module link_regs_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_a_i,
  input wire logic wr_b_i,
  output logic [7:0] a_rdata_o,
  output logic [7:0] b_rdata_o
);
  logic [7:0] mem_a [256];
  logic [7:0] mem_b [256];
  initial begin
    foreach (mem_a[i]) begin
      mem_a[i] = 8'h00;
      mem_b[i] = 8'h00;
    end
  end
  always @(posedge sys_clk_i) begin
    if (wr_a_i) begin
      mem_a[wr_addr_i] <= wr_data_i;
    end
    if (wr_b_i) begin
      mem_b[wr_addr_i] <= wr_data_i;
    end
  end
  // Read data follows the request address in the same cycle
  assign a_rdata_o = mem_a[rd_addr_i];
  assign b_rdata_o = mem_b[rd_addr_i];
endmodule // link_regs_model

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pix_clk_i = 1'b0;
  logic [6:0] cfg = 7'h7f;
  logic rep = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic [6:0] dev = 7'h00;
  logic [7:0] ra = 8'h00;
  logic [7:0] wd = 8'h00;
  logic ack, fwd, wa, wb, ws;
  logic [7:0] rdata, a_rd, b_rd, oa, ow, r, v;
  logic [2:0] las = 3'h1;
  logic [7:0] sha [256];
  logic [7:0] shb [256];
  logic [7:0] modes [6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'hff, 8'h04};
  logic [11:0] exp_q [$];
  logic [11:0] note;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  port_select_freq_counter i_dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pix_clk_i(pix_clk_i),
    .configured_device_address_i(cfg), .replicate_mode_i(rep),
    .acc_valid_i(vld), .acc_write_i(wr), .acc_dev_addr_i(dev),
    .acc_reg_addr_i(ra), .acc_wdata_i(wd), .link_a_rdata_i(a_rd),
    .link_b_rdata_i(b_rd), .acc_ack_o(ack), .acc_rdata_o(rdata),
    .reg_addr_o(oa), .reg_wdata_o(ow), .wr_link_a_o(wa), .wr_link_b_o(wb),
    .wr_shared_o(ws), .remote_fwd_link_b_o(fwd));
  link_regs_model i_links (
    .sys_clk_i(sys_clk_i), .rd_addr_i(ra), .wr_addr_i(oa), .wr_data_i(ow),
    .wr_a_i(wa), .wr_b_i(wb), .a_rdata_o(a_rd), .b_rdata_o(b_rd));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    forever begin
      #62 pix_clk_i = 1'b1;
      #63 pix_clk_i = 1'b0;
    end
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    check(12'(exp_q.size()), 12'h000);
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    vld = 1'b0;
    repeat (n) @(negedge sys_clk_i);
  endtask
  // ----
  // One access; the expected answer is queued for the monitor
  // ----
  task automatic acc(input logic w, input logic [6:0] d, input logic [7:0] a,
                     input logic [7:0] x);
    logic hit2, prim, to_b;
    logic [2:0] st;
    logic [7:0] e;
    hit2 = las[2] && d == cfg + 7'h01;
    prim = d == cfg;
    to_b = hit2 || (prim && !las[2] && las[1]);
    st = 3'b000;
    e = (a == 8'h1e) ? {5'h00, las} : (to_b ? shb[a] : sha[a]);
    // Only an access that the block answers may touch the shadow state
    if (w && (hit2 || prim) && a == 8'h1e) begin
      las = x[2:0];
    end else if (w && (hit2 || prim) && a != 8'h1f) begin
      st = hit2 ? 3'b011 : (las[2] ? 3'b101 : {las[0], las[1], |las[1:0]});
      if (st[2]) sha[a] = x;
      if (st[1]) shb[a] = x;
    end
    if (hit2 || prim) exp_q.push_back({!w && a != 8'h1f, st, e});
    vld = 1'b1;
    wr = w;
    dev = d;
    ra = a;
    wd = x;
    @(negedge sys_clk_i);
  endtask
  task automatic range_chk(input int lo, input int hi);
    checked++;
    if ($isunknown(rdata) || rdata < lo || rdata > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, rdata, lo);
    end
  endtask
  task automatic freq(input logic [7:0] n, input int lo, input int hi);
    acc(1'b1, cfg, 8'h1f, n);
    idle(int'(n) + 6);
    acc(1'b0, cfg, 8'h1f, 8'h00);
    idle(2);
    range_chk(lo, hi);
  endtask
  always @(negedge sys_clk_i) begin
    if (ack === 1'b1) begin
      note = (exp_q.size() == 0) ? 12'hfff : exp_q.pop_front();
      check({note[11], wa, wb, ws, note[11] ? rdata : note[7:0]}, note);
    end
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    foreach (sha[i]) begin
      sha[i] = 8'h00;
      shb[i] = 8'h00;
    end
    void'($urandom(59));
    repeat (5) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    idle(1);
    acc(1'b0, cfg, 8'h1e, 8'h00);
    acc(1'b0, cfg, 8'h1f, 8'h00);
    idle(2);
    range_chk(0, 0);
    for (int p = 0; p < 2; p++) begin
      foreach (modes[m]) begin
        acc(1'b1, cfg, 8'h1e, modes[m]);
        rep = 1'($urandom);
        idle(3);
        check({11'h000, fwd}, {11'h000, rep & las[2]});
        for (int k = 0; k < 3; k++) begin
          r = 8'($urandom_range(29, 0));
          v = 8'($urandom);
          acc(1'b1, cfg + k[6:0], r, v);
          idle(1);
          acc(1'b0, cfg + k[6:0], r, 8'h00);
          acc(1'b0, cfg, 8'h1e, 8'h00);
          idle(2);
        end
      end
      cfg = 7'($urandom);
    end
    acc(1'b1, cfg, 8'h1e, 8'h01);
    freq(8'd0, 0, 0);
    freq(8'd100, 7, 9);
    freq(8'd255, 19, 22);
    acc(1'b1, cfg, 8'h1f, 8'd200);
    idle(50);
    freq(8'd40, 2, 5);
    complete_run();
  end
endmodule // tb_top
